// ### include/adc_pkg.sv
// constants and types shared by the two-wire converter front end
package adc_pkg;

  // ==========================================================
  // bus timing
  localparam int SCL_MIN_KHZ = 100;
  localparam int SCL_MAX_KHZ = 3400;

  // ==========================================================
  // converter core timing, 25 MHz core clock
  localparam int CLK_PERIOD_NS = 40;
  localparam int CONV_TIME_NS  = 6670;
  localparam int CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0] CONV_LOAD = 8'(CONV_CYCLES - 1);

  // ==========================================================
  // word and byte layout
  localparam int RESULT_W   = 12;
  localparam int PREFIX_W   = 5;
  localparam int ADDR_PREFIX_LSB = 3;
  localparam int ADDR_SEL_LSB    = 1;
  localparam int ADDR_RW_BIT     = 0;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // command byte fields
  localparam int CMD_SD_BIT   = 7;
  localparam int CMD_CH_MSB   = 6;
  localparam int CMD_CH_LSB   = 4;
  localparam int CMD_PD_MSB   = 3;
  localparam int CMD_PD_LSB   = 2;

  // ==========================================================
  // reset values
  localparam logic [3:0]  INPUT_SEL_RST = 4'h0;
  localparam logic [1:0]  POWER_SEL_RST = 2'h0;
  localparam logic [11:0] RESULT_RST    = 12'h000;
  localparam logic [7:0]  BYTE_RST      = 8'h00;
  localparam logic [1:0]  STRAP_WAIT    = 2'h2;

  // ==========================================================
  // link state machine
  typedef enum logic [7:0] {
    ST_IDLE     = 8'h01,
    ST_ADDR     = 8'h02,
    ST_ADDR_ACK = 8'h04,
    ST_RX       = 8'h08,
    ST_RX_ACK   = 8'h10,
    ST_TX       = 8'h20,
    ST_TX_ACK   = 8'h40,
    ST_IGNORE   = 8'h80
  } link_state_t;

endpackage

// ### include/conv_if.sv
// carrier between the link front end and the converter core, core clock domain
`timescale 1ns/10ps

interface conv_if;
  logic        cmd_valid;
  logic [7:0]  cmd;
  logic        addressed;
  logic [11:0] result;
  logic        result_toggle;

  modport ctrl (output cmd_valid, output cmd, output addressed, input result, input result_toggle);
  modport core (input cmd_valid, input cmd, input addressed, output result, output result_toggle);
endinterface

// ### design/conv_core.sv
// converter core sequencing: command latch, conversion timing, result capture
`timescale 1ns/10ps

module conv_core
  (
  input  wire logic        clk,
  input  wire logic        srst,
  conv_if.core             cv,
  input  wire logic [11:0] analog_code,
  output logic [3:0]       input_sel,
  output logic [1:0]       power_sel,
  output logic             busy,
  output logic             core_clk_en
  );

  logic [7:0] cnt;

  // ==========================================================
  // command latch and conversion timing
  // a command arriving mid-conversion is dropped so a result is never torn
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      busy      <= 1'b0;
      cnt       <= 8'h00;
      input_sel <= adc_pkg::INPUT_SEL_RST;
      power_sel <= adc_pkg::POWER_SEL_RST;
    end
    else if (cv.cmd_valid && !busy)
    begin
      busy      <= 1'b1;
      cnt       <= adc_pkg::CONV_LOAD;
      input_sel <= {cv.cmd[adc_pkg::CMD_SD_BIT], cv.cmd[adc_pkg::CMD_CH_MSB:adc_pkg::CMD_CH_LSB]};
      power_sel <= cv.cmd[adc_pkg::CMD_PD_MSB:adc_pkg::CMD_PD_LSB];
    end
    else if (busy)
    begin
      cnt <= cnt - 8'h01;
      if (cnt == 8'h00)
        busy <= 1'b0;
    end
  end

  // ==========================================================
  // result capture, 12-bit straight binary code
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cv.result        <= adc_pkg::RESULT_RST;
      cv.result_toggle <= 1'b0;
    end
    else if (busy && cnt == 8'h00)
    begin
      cv.result        <= analog_code;
      cv.result_toggle <= ~cv.result_toggle;
    end
  end

  // ==========================================================
  // internal clock gate: off unless converting or addressed
  always_ff @(posedge clk)
  begin
    if (srst)
      core_clk_en <= 1'b0;
    else
      core_clk_en <= busy || cv.addressed || (cv.cmd_valid && !busy);
  end

  // ==========================================================
  // checks
  conv_len_a: assert property (@(posedge clk) disable iff (srst)
    $rose(busy) |-> ##165 busy ##1 !busy)
    else $error("conversion length wrong");

  clk_gate_a: assert property (@(posedge clk) disable iff (srst)
    busy |=> core_clk_en)
    else $error("core clock gated while converting");

  conv_done_c: cover property (@(posedge clk) disable iff (srst) $fell(busy));

endmodule

// ### design/adc_two_wire_slave.sv
// two-wire slave front end of the 12-bit converter, link side on its own clock
`timescale 1ns/10ps

// Summary of operation
// - slave only; master makes clock, START and STOP, we never drive the clock
// - serial clock from 0.1 to 3.4 MHz must be resolved by the link sampler
// - data changes while clock high are conditions, never data
// - data falling while clock high is START
// - data rising while clock high is STOP
// - eight-bit bytes, one clock per bit, ninth bit acknowledged by receiver
// - no limit on bytes per transfer
// - acknowledger holds data low through the ninth pulse high phase
// - on master not-acknowledge the device releases data for STOP
// - in write transfers the address and every data byte are acknowledged
// - STOP or repeated START ends a transfer; repeated START starts the next
// - first byte after START is the address byte
// - address is fixed prefix then two strap bits caught at power-up
// - address bit zero: one reads, zero writes
// - acknowledge only after full hardware address match
// - core and its clock off unless converting or addressed
// - result is a 12-bit code, step is reference over 4096
// - read returns four zeros and top nibble, then low byte
// - written byte is a command; receiving it starts a conversion unless one is already running
module adc_two_wire_slave
  #(parameter logic [4:0] ADDR_PREFIX = 5'h0B)  // arbitrary value
  (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        link_clk,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        addr_select_pin_hi,
  input  wire logic        addr_select_pin_lo,
  input  wire logic [11:0] analog_code,
  output logic [3:0]       input_sel,
  output logic [1:0]       power_sel,
  output logic             conv_busy,
  output logic             core_clk_en
  );

  conv_if cv ();

  adc_pkg::link_state_t state;

  logic [1:0]  rst_sync;
  logic        link_rst;
  logic [1:0]  scl_meta;
  logic [1:0]  sda_meta;
  logic [1:0]  strap_meta;
  logic [1:0]  res_meta;
  logic        scl_d;
  logic        sda_d;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic [1:0]  strap_cnt;
  logic [1:0]  own_sel;
  logic [2:0]  bit_cnt;
  logic        byte_done;
  logic [7:0]  shreg;
  logic        rw;
  logic        byte_sel;
  logic        master_ack;
  logic        addr_active;
  logic        cmd_tgl;
  logic [7:0]  cmd_byte;
  logic        res_seen;
  logic [11:0] res_hold;
  logic [1:0]  cmd_meta;
  logic        cmd_seen;
  logic [1:0]  addr_meta;
  logic [7:0]  first_tx;
  logic [7:0]  next_tx;

  // ==========================================================
  // helpers
  function automatic logic addr_match(input logic [7:0] b, input logic [1:0] sel);
    addr_match = (b[7:adc_pkg::ADDR_PREFIX_LSB] == ADDR_PREFIX) && (b[2:adc_pkg::ADDR_SEL_LSB] == sel);
  endfunction

  function automatic logic [7:0] tx_byte(input logic sel, input logic [11:0] res);
    tx_byte = sel ? res[7:0] : {4'h0, res[11:8]};
  endfunction

  // whole byte built first so its top bit can drive the line at the load
  assign first_tx = tx_byte(1'b0, res_hold);
  assign next_tx  = tx_byte(byte_sel, res_hold);

  // open drain: only ever pull low, the clock line is never driven
  assign sda_out = 1'b0;

  // ==========================================================
  // link reset and pin synchronisers
  // link_clk oversamples a 3.4 MHz clock at least four times per high phase
  always_ff @(posedge link_clk)
  begin
    rst_sync <= {rst_sync[0], srst};
  end
  assign link_rst = rst_sync[1];

  always_ff @(posedge link_clk)
  begin
    scl_meta   <= {scl_meta[0], scl_in};
    sda_meta   <= {sda_meta[0], sda_in};
    strap_meta <= {strap_meta[0], addr_select_pin_lo};
    res_meta   <= {res_meta[0], cv.result_toggle};
  end

  logic [1:0] strap_hi_meta;
  always_ff @(posedge link_clk)
  begin
    strap_hi_meta <= {strap_hi_meta[0], addr_select_pin_hi};
  end

  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_meta[1];
      sda_d <= sda_meta[1];
    end
  end

  assign scl_rise  = scl_meta[1] && !scl_d;
  assign scl_fall  = !scl_meta[1] && scl_d;
  assign start_det = scl_meta[1] && scl_d && sda_d && !sda_meta[1];
  assign stop_det  = scl_meta[1] && scl_d && !sda_d && sda_meta[1];

  // ==========================================================
  // strap capture once after reset release, then held
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      strap_cnt <= 2'h0;
      own_sel   <= 2'h0;
    end
    else if (strap_cnt != 2'h3)
    begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == adc_pkg::STRAP_WAIT)
        own_sel <= {strap_hi_meta[1], strap_meta[1]};
    end
  end

  // ==========================================================
  // result word from the core, stable between its toggles
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      res_seen <= 1'b0;
      res_hold <= adc_pkg::RESULT_RST;
    end
    else if (res_meta[1] != res_seen)
    begin
      res_seen <= res_meta[1];
      res_hold <= cv.result;
    end
  end

  // ==========================================================
  // link state machine; conditions override every state
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      state       <= adc_pkg::ST_IDLE;
      bit_cnt     <= 3'h0;
      byte_done   <= 1'b0;
      shreg       <= adc_pkg::BYTE_RST;
      rw          <= 1'b0;
      byte_sel    <= 1'b0;
      master_ack  <= 1'b0;
      sda_oe      <= 1'b0;
      addr_active <= 1'b0;
      cmd_tgl     <= 1'b0;
      cmd_byte    <= adc_pkg::BYTE_RST;
    end
    else if (start_det)
    begin
      state       <= adc_pkg::ST_ADDR;
      bit_cnt     <= 3'h0;
      byte_done   <= 1'b0;
      sda_oe      <= 1'b0;
      addr_active <= 1'b0;
    end
    else if (stop_det)
    begin
      state       <= adc_pkg::ST_IDLE;
      bit_cnt     <= 3'h0;
      byte_done   <= 1'b0;
      sda_oe      <= 1'b0;
      addr_active <= 1'b0;
    end
    else
    begin
      case (state)
        adc_pkg::ST_ADDR, adc_pkg::ST_RX:
        begin
          if (scl_rise)
          begin
            shreg   <= {shreg[6:0], sda_meta[1]};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == adc_pkg::LAST_BIT)
              byte_done <= 1'b1;
          end
          else if (scl_fall && byte_done)
          begin
            byte_done <= 1'b0;
            bit_cnt   <= 3'h0;
            if (state == adc_pkg::ST_RX)
            begin
              state    <= adc_pkg::ST_RX_ACK;
              sda_oe   <= 1'b1;
              cmd_byte <= shreg;
              cmd_tgl  <= ~cmd_tgl;
            end
            else if (addr_match(shreg, own_sel))
            begin
              state       <= adc_pkg::ST_ADDR_ACK;
              sda_oe      <= 1'b1;
              rw          <= shreg[adc_pkg::ADDR_RW_BIT];
              addr_active <= 1'b1;
            end
            else
              state <= adc_pkg::ST_IGNORE;
          end
        end
        adc_pkg::ST_ADDR_ACK:
        begin
          // held low from one fall to the next spans the whole ninth high phase
          if (scl_fall)
          begin
            if (rw)
            begin
              state    <= adc_pkg::ST_TX;
              shreg    <= first_tx;
              sda_oe   <= ~first_tx[7];
              byte_sel <= 1'b1;
            end
            else
            begin
              state  <= adc_pkg::ST_RX;
              sda_oe <= 1'b0;
            end
          end
        end
        adc_pkg::ST_RX_ACK:
        begin
          if (scl_fall)
          begin
            state  <= adc_pkg::ST_RX;
            sda_oe <= 1'b0;
          end
        end
        adc_pkg::ST_TX:
        begin
          if (scl_rise)
          begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == adc_pkg::LAST_BIT)
              byte_done <= 1'b1;
          end
          else if (scl_fall)
          begin
            if (byte_done)
            begin
              state     <= adc_pkg::ST_TX_ACK;
              sda_oe    <= 1'b0;
              byte_done <= 1'b0;
              bit_cnt   <= 3'h0;
            end
            else
            begin
              shreg  <= {shreg[6:0], 1'b0};
              sda_oe <= ~shreg[6];
            end
          end
        end
        adc_pkg::ST_TX_ACK:
        begin
          if (scl_rise)
            master_ack <= !sda_meta[1];
          else if (scl_fall)
          begin
            if (master_ack)
            begin
              state    <= adc_pkg::ST_TX;
              shreg    <= next_tx;
              sda_oe   <= ~next_tx[7];
              byte_sel <= ~byte_sel;
            end
            else
            begin
              state  <= adc_pkg::ST_IGNORE;
              sda_oe <= 1'b0;
            end
          end
        end
        adc_pkg::ST_IDLE, adc_pkg::ST_IGNORE:
        begin
          sda_oe <= 1'b0;
        end
        default:
        begin
          state  <= adc_pkg::ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // crossings into the core clock domain
  // the command byte is stable for many link clocks before its toggle lands
  always_ff @(posedge clk)
  begin
    cmd_meta  <= {cmd_meta[0], cmd_tgl};
    addr_meta <= {addr_meta[0], addr_active};
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cmd_seen     <= 1'b0;
      cv.cmd_valid <= 1'b0;
      cv.cmd       <= adc_pkg::BYTE_RST;
      cv.addressed <= 1'b0;
    end
    else
    begin
      cmd_seen     <= cmd_meta[1];
      cv.cmd_valid <= cmd_meta[1] != cmd_seen;
      cv.addressed <= addr_meta[1];
      if (cmd_meta[1] != cmd_seen)
        cv.cmd <= cmd_byte;
    end
  end

  conv_core u_core
    (
    .clk         (clk),
    .srst        (srst),
    .cv          (cv),
    .analog_code (analog_code),
    .input_sel   (input_sel),
    .power_sel   (power_sel),
    .busy        (conv_busy),
    .core_clk_en (core_clk_en)
    );

  // ==========================================================
  // checks, link domain
  start_to_addr_a: assert property (@(posedge link_clk) disable iff (link_rst)
    start_det |=> state == adc_pkg::ST_ADDR && !sda_oe)
    else $error("start not taken");

  stop_to_idle_a: assert property (@(posedge link_clk) disable iff (link_rst)
    stop_det |=> state == adc_pkg::ST_IDLE && !sda_oe)
    else $error("stop not taken");

  stable_high_a: assert property (@(posedge link_clk) disable iff (link_rst)
    scl_meta[1] && scl_d && !start_det && !stop_det |=> $stable(sda_oe))
    else $error("data drive changed while clock high");

  addr_ack_a: assert property (@(posedge link_clk) disable iff (link_rst)
    state == adc_pkg::ST_ADDR && scl_fall && byte_done && addr_match(shreg, own_sel)
    |=> sda_oe && state == adc_pkg::ST_ADDR_ACK)
    else $error("matching address not acknowledged");

  mismatch_quiet_a: assert property (@(posedge link_clk) disable iff (link_rst)
    state == adc_pkg::ST_IGNORE |-> !sda_oe)
    else $error("data driven while ignoring bus");

  rx_ack_a: assert property (@(posedge link_clk) disable iff (link_rst)
    state == adc_pkg::ST_RX && scl_fall && byte_done && !start_det && !stop_det
    |=> state == adc_pkg::ST_RX_ACK && sda_oe)
    else $error("written byte not acknowledged");

  cmd_pass_a: assert property (@(posedge link_clk) disable iff (link_rst)
    state == adc_pkg::ST_RX && scl_fall && byte_done && !start_det && !stop_det
    |=> cmd_tgl != $past(cmd_tgl) && cmd_byte == $past(shreg))
    else $error("command byte not passed on");

  nack_release_a: assert property (@(posedge link_clk) disable iff (link_rst)
    state == adc_pkg::ST_TX_ACK && scl_fall && !master_ack && !start_det && !stop_det
    |=> !sda_oe && state == adc_pkg::ST_IGNORE)
    else $error("data not released after not-acknowledge");

  first_byte_a: assert property (@(posedge link_clk) disable iff (link_rst)
    state == adc_pkg::ST_ADDR_ACK && scl_fall && rw && !start_det && !stop_det
    |=> shreg == {4'h0, $past(res_hold[11:8])} && sda_oe)
    else $error("first read byte wrong");

  read_done_c: cover property (@(posedge link_clk) disable iff (link_rst)
    state == adc_pkg::ST_TX_ACK ##1 state == adc_pkg::ST_IGNORE);
  write_cmd_c: cover property (@(posedge link_clk) disable iff (link_rst)
    state == adc_pkg::ST_RX_ACK);
  mismatch_c: cover property (@(posedge link_clk) disable iff (link_rst)
    state == adc_pkg::ST_ADDR ##1 state == adc_pkg::ST_IGNORE);

endmodule

// ### bench/two_wire_master.sv
// bus master model that clocks and frames transfers toward the converter
`timescale 1ns/10ps

module two_wire_master
  (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl_low,
  output logic      sda_low
  );
  // half period of the serial clock in core clock cycles
  int half = 4;

  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // ==========================================================
  // timing
  task automatic speed(input int n);
    half = n;
  endtask

  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  // ==========================================================
  // bit level
  // data moves a quarter of the low phase after the fall so the slave never sees a false condition
  task automatic put_bit(input logic b);
    hold(half / 4);
    sda_low = !b;
    hold(half - half / 4);
    scl_low = 1'b0;
    hold(half);
    scl_low = 1'b1;
  endtask

  task automatic get_bit(output logic b);
    hold(half / 4);
    sda_low = 1'b0;
    hold(half - half / 4);
    scl_low = 1'b0;
    hold(half / 2);
    b = sda_line;
    hold(half - half / 2);
    scl_low = 1'b1;
  endtask

  // ==========================================================
  // conditions and bytes
  // both lines released before the data falls, from idle or after a bit
  task automatic start_cond();
    hold(half / 4);
    sda_low = 1'b0;
    hold(half - half / 4);
    scl_low = 1'b0;
    hold(half);
    sda_low = 1'b1;
    hold(half);
    scl_low = 1'b1;
  endtask

  task automatic stop_cond();
    hold(half / 4);
    sda_low = 1'b1;
    hold(half - half / 4);
    scl_low = 1'b0;
    hold(half);
    sda_low = 1'b0;
    hold(33);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i]);
    get_bit(b);
    ack = !b;
  endtask

  task automatic recv_byte(input logic give_ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      get_bit(d[i]);
    put_bit(!give_ack);
  endtask
endmodule

// ### bench/adc_two_wire_slave_interface_test.sv
// self-checking bench for the two-wire converter front end
`timescale 1ns/10ps

module adc_two_wire_slave_interface_test;
  localparam logic [4:0]  prefix = 5'h0B;  // arbitrary value
  localparam logic [11:0] code   = 12'hA5C;

  logic        clk;
  logic        link_clk;
  logic        srst;
  logic        strap_hi;
  logic        strap_lo;
  logic [11:0] analog_code;
  logic        sda_oe;
  logic        sda_out;
  logic        scl_low;
  logic        sda_low;
  logic [3:0]  input_sel;
  logic [1:0]  power_sel;
  logic        conv_busy;
  logic        core_clk_en;
  wire logic   scl_line;
  wire logic   sda_line;
  int          n_fail;
  int          comparisons;
  int          busy_len;
  int          last_busy_len;

  // both lines are pulled up; either party may pull data low, only the master pulls the clock low
  assign scl_line = !scl_low;
  assign sda_line = !(sda_oe | sda_low);

  always #20 clk = ~clk;

  initial
  begin
    clk = 1'b0;
    link_clk = 1'b0;
    #3;
    forever #6 link_clk = ~link_clk;
  end

  adc_two_wire_slave #(.ADDR_PREFIX(prefix)) u_dut (.clk(clk), .srst(srst), .link_clk(link_clk),
    .scl_in(scl_line), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin_hi(strap_hi),
    .addr_select_pin_lo(strap_lo), .analog_code(analog_code), .input_sel(input_sel),
    .power_sel(power_sel), .conv_busy(conv_busy), .core_clk_en(core_clk_en));

  two_wire_master u_master (.clk(clk), .sda_line(sda_line), .scl_low(scl_low), .sda_low(sda_low));

  always @(posedge clk)
  begin
    if (conv_busy)
      busy_len <= busy_len + 1;
    else if (busy_len != 0)
    begin
      last_busy_len <= busy_len;
      busy_len <= 0;
    end
  end

  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wait_idle();
    int i;
    i = 0;
    while (conv_busy !== 1'b0 && i < 400)
    begin
      @(negedge clk);
      i++;
    end
    if (conv_busy !== 1'b0)
    begin
      n_fail++;
      $display("BAD conversion end expected 0 seen %b", conv_busy);
      report_and_stop();
    end
    repeat (3) @(negedge clk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    check("sda_oe", 0, sda_oe);
    check("sda_out", 0, sda_out);
    check("input_sel", 0, input_sel);
    check("power_sel", 0, power_sel);
    check("conv_busy", 0, conv_busy);
    check("core_clk_en", 0, core_clk_en);
  endtask

  task automatic t_write();
    logic ack;
    u_master.start_cond();
    u_master.send_byte({prefix, 2'b10, 1'b0}, ack);
    check("write address ack", 1, ack);
    check("clock enable addressed", 1, core_clk_en);
    u_master.send_byte(8'hB4, ack);
    check("command ack", 1, ack);
    check("busy after command", 1, conv_busy);
    u_master.send_byte(8'h4C, ack);
    check("second command ack", 1, ack);
    check("channel kept while busy", 4'hB, input_sel);
    u_master.stop_cond();
    wait_idle();
    check("busy length", adc_pkg::CONV_CYCLES, last_busy_len);
    check("power select", 2'b01, power_sel);
    check("clock enable idle", 0, core_clk_en);
  endtask

  task automatic t_read();
    logic       ack;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    u_master.start_cond();
    u_master.send_byte({prefix, 2'b10, 1'b1}, ack);
    check("read address ack", 1, ack);
    u_master.recv_byte(1'b1, b0);
    u_master.recv_byte(1'b1, b1);
    u_master.recv_byte(1'b0, b2);
    check("result high byte", {4'h0, code[11:8]}, b0);
    check("result low byte", code[7:0], b1);
    check("third byte", {4'h0, code[11:8]}, b2);
    repeat (2) @(negedge clk);
    check("released after nack", 0, sda_oe);
    u_master.stop_cond();
  endtask

  task automatic t_miss();
    logic ack;
    u_master.start_cond();
    u_master.send_byte({prefix ^ 5'h10, 2'b10, 1'b0}, ack);
    check("wrong prefix ack", 0, ack);
    u_master.send_byte(8'h00, ack);
    check("ignored byte ack", 0, ack);
    u_master.start_cond();
    u_master.send_byte({prefix, 2'b01, 1'b0}, ack);
    check("wrong select ack", 0, ack);
    u_master.start_cond();
    u_master.send_byte({prefix, 2'b10, 1'b0}, ack);
    check("repeated start ack", 1, ack);
    u_master.send_byte(8'h08, ack);
    check("command ack", 1, ack);
    u_master.stop_cond();
    wait_idle();
    check("input select", 4'h0, input_sel);
    check("power select", 2'b10, power_sel);
  endtask

  // slowest documented serial clock, 0.1 MHz
  task automatic t_slow();
    logic ack;
    u_master.speed(125);
    u_master.start_cond();
    u_master.send_byte({prefix, 2'b10, 1'b0}, ack);
    check("slow address ack", 1, ack);
    u_master.send_byte(8'hFF, ack);
    check("slow command ack", 1, ack);
    u_master.stop_cond();
    u_master.speed(4);
    wait_idle();
    check("input select", 4'hF, input_sel);
    check("power select", 2'b11, power_sel);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    srst = 1'b1;
    strap_hi = 1'b1;
    strap_lo = 1'b0;
    analog_code = code;
    repeat (3) @(negedge clk);
    t_reset();
    srst = 1'b0;
    repeat (20) @(negedge clk);
    t_write();
    t_read();
    t_miss();
    t_slow();
    report_and_stop();
  end
endmodule
